// ===== hdl/efh_pkg.sv
// Shared constants and types for the event flag handler
package efh_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_EVENTS = 8;
  localparam int LEVEL_SIZE = 4;
  localparam int DATA_W     = 32;
  localparam int REG_W      = 8;

  // ==========================================================
  // Register byte offsets
  localparam logic [4:0] OFS_EVENT_FLAGS   = 5'h00;
  localparam logic [4:0] OFS_EVENT_ENABLE  = 5'h04;
  localparam logic [4:0] OFS_EVENT_TOPCODE = 5'h08;
  localparam logic [4:0] OFS_EVENT_SUMMARY = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STATUS    = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK      = 5'h14;

  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0] RST_EVENT_FLAGS  = 8'h00;
  localparam logic [7:0] RST_EVENT_ENABLE = 8'h00;
  localparam logic [7:0] RST_IRQ_STATUS   = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK     = 8'h00;
  localparam logic [7:0] TOP_CODE_NONE    = 8'hFF;
  localparam int         SUM_HIGH_BIT     = 1;
  localparam int         SUM_LOW_BIT      = 0;
  localparam int         PIN_ZERO_EVENT   = 0;
  localparam int         PIN_ONE_EVENT    = 4;

  // ==========================================================
  // Per-event latch state
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic flag;
  } efh_bit_state_t;

  // Register file and output state
  typedef struct packed {
    logic [7:0]  enable;
    logic [7:0]  irq_status;
    logic [7:0]  irq_mask;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        core_a;
    logic        core_b;
    logic        irq;
  } efh_state_t;

endpackage

// ===== hdl/efh_edge_latch.sv
// One event source: synchroniser, rising-edge detector and sticky flag
`timescale 1ns/1ps
module efh_edge_latch (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Source and control
  input  wire logic src_async,
  input  wire logic enable,
  input  wire logic clear,
  // Result
  output logic      flag,
  output logic      set_pulse
);

  efh_pkg::efh_bit_state_t state_ff;
  efh_pkg::efh_bit_state_t nxt_state;
  logic                    rise;

  // ==========================================================
  // Next state: only sync2 and prev feed the edge detector
  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.sync1 = src_async;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.prev  = state_ff.sync2;
    rise            = state_ff.sync2 & ~state_ff.prev & enable;
    // Set beats a clear arriving in the same cycle
    nxt_state.flag  = rise | (state_ff.flag & ~clear);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign flag      = state_ff.flag;
  assign set_pulse = rise;

  // ==========================================================
  // Checks
  a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
    rise |=> flag) else $error("flag missed an enabled rising edge");
  a_flag_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (!enable && !flag) |=> !flag) else $error("flag set while disabled");
  a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (flag && !clear) |=> flag) else $error("flag dropped without clear");

endmodule // efh_edge_latch

// ===== hdl/efh_top.sv
// Event flag handler: eight latched events, two levels, APB registers
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module efh_top #(
  parameter int NUM_EVENTS = efh_pkg::NUM_EVENTS,
  parameter int LEVEL_SIZE = efh_pkg::LEVEL_SIZE
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral event sources, asynchronous
  input  wire logic [7:0]  event_src,
  input  wire logic        input_port_pin_zero,
  input  wire logic        input_port_pin_one,
  // Core event inputs
  output logic             core_event_input_a,
  output logic             core_event_input_b,
  // Interrupt
  output logic             irq
);

  // ==========================================================
  // Elaboration checks
  if (NUM_EVENTS != 8)
    $error("efh_top serves exactly eight events");
  if (LEVEL_SIZE * 2 != NUM_EVENTS)
    $error("efh_top needs two levels of equal size");

  // ==========================================================
  // Declarations
  efh_pkg::efh_state_t state_ff;
  efh_pkg::efh_state_t nxt_state;
  logic [7:0]          src_merged;
  logic [7:0]          event_flags;
  logic [7:0]          set_pulse;
  logic [7:0]          flag_clear;
  logic [7:0]          top_code;
  logic [7:0]          summary;
  logic                high_level_pending;
  logic                low_level_pending;
  logic                setup_phase;
  logic                commit;
  logic                wr_commit;
  logic [4:0]          reg_ofs;
  logic                addr_hit;
  logic [7:0]          rd_value;

  // ==========================================================
  // Source merge: port pin requests join events zero and four
  always_comb
  begin
    src_merged                         = event_src;
    src_merged[efh_pkg::PIN_ZERO_EVENT] = event_src[efh_pkg::PIN_ZERO_EVENT]
                                          | input_port_pin_zero;
    src_merged[efh_pkg::PIN_ONE_EVENT]  = event_src[efh_pkg::PIN_ONE_EVENT]
                                          | input_port_pin_one;
  end

  // ==========================================================
  // Per-event latches
  for (genvar n = 0; n < NUM_EVENTS; n++)
  begin : g_event
    efh_edge_latch u_latch (
      .pclk      (pclk),
      .presetn   (presetn),
      .src_async (src_merged[n]),
      .enable    (state_ff.enable[n]),
      .clear     (flag_clear[n]),
      .flag      (event_flags[n]),
      .set_pulse (set_pulse[n])
    );
  end

  // ==========================================================
  // Bus phase decode
  assign setup_phase = psel & ~penable;
  assign commit      = psel & penable & state_ff.pready;
  assign wr_commit   = commit & pwrite;
  assign reg_ofs     = paddr[4:0];
  assign addr_hit    = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0)
                       && (reg_ofs <= efh_pkg::OFS_IRQ_MASK);

  // W1C on the flag register, zero bits leave flags alone
  assign flag_clear = (wr_commit && addr_hit && reg_ofs == efh_pkg::OFS_EVENT_FLAGS)
                      ? pwdata[7:0] : 8'h00;

  // ==========================================================
  // Level summary, taken from latched flags, never raw sources
  assign high_level_pending = |event_flags[7:4];
  assign low_level_pending  = |event_flags[3:0];

  always_comb
  begin
    summary                        = 8'h00;
    summary[efh_pkg::SUM_HIGH_BIT] = high_level_pending;
    summary[efh_pkg::SUM_LOW_BIT]  = low_level_pending;
  end

  // Highest set flag; later iterations override so the top index wins
  always_comb
  begin
    top_code = efh_pkg::TOP_CODE_NONE;
    for (int i = 0; i < NUM_EVENTS; i++)
    begin
      if (event_flags[i])
        top_code = 8'(i);
    end
  end

  // ==========================================================
  // Read mux; unmapped offsets read zero
  always_comb
  begin
    case (reg_ofs)
      efh_pkg::OFS_EVENT_FLAGS:   rd_value = event_flags;
      efh_pkg::OFS_EVENT_ENABLE:  rd_value = state_ff.enable;
      efh_pkg::OFS_EVENT_TOPCODE: rd_value = top_code;
      efh_pkg::OFS_EVENT_SUMMARY: rd_value = summary;
      efh_pkg::OFS_IRQ_STATUS:    rd_value = state_ff.irq_status;
      efh_pkg::OFS_IRQ_MASK:      rd_value = state_ff.irq_mask;
      default:                    rd_value = 8'h00;
    endcase
    if (!addr_hit)
      rd_value = 8'h00;
  end

  // ==========================================================
  // Next state of registers and outputs
  always_comb
  begin
    nxt_state = state_ff;

    // Zero-wait answer: ready is raised for the access after every setup
    nxt_state.pready = setup_phase;

    // Read data and error are captured in setup so outputs come from flops
    if (setup_phase)
    begin
      nxt_state.prdata  = {24'h000000, pwrite ? 8'h00 : rd_value};
      nxt_state.pslverr = ~addr_hit;
    end
    else if (commit)
    begin
      nxt_state.pslverr = 1'b0;
    end

    // Enable and mask registers
    if (wr_commit && addr_hit && reg_ofs == efh_pkg::OFS_EVENT_ENABLE)
      nxt_state.enable = pwdata[7:0];
    if (wr_commit && addr_hit && reg_ofs == efh_pkg::OFS_IRQ_MASK)
      nxt_state.irq_mask = pwdata[7:0];

    // Sticky interrupt status: a new set wins over a same-cycle clear
    if (wr_commit && addr_hit && reg_ofs == efh_pkg::OFS_IRQ_STATUS)
      nxt_state.irq_status = state_ff.irq_status & ~pwdata[7:0];
    nxt_state.irq_status = nxt_state.irq_status | set_pulse;

    // Core event inputs follow the two levels, one flop late
    nxt_state.core_a = high_level_pending;
    nxt_state.core_b = low_level_pending;

    // Level interrupt while any unmasked status bit stands
    nxt_state.irq = |(nxt_state.irq_status & nxt_state.irq_mask);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff            <= '0;
      state_ff.enable     <= efh_pkg::RST_EVENT_ENABLE;
      state_ff.irq_status <= efh_pkg::RST_IRQ_STATUS;
      state_ff.irq_mask   <= efh_pkg::RST_IRQ_MASK;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Outputs straight from flops
  assign prdata             = state_ff.prdata;
  assign pready             = state_ff.pready;
  assign pslverr            = state_ff.pslverr;
  assign core_event_input_a = state_ff.core_a;
  assign core_event_input_b = state_ff.core_b;
  assign irq                = state_ff.irq;

  // ==========================================================
  // Checks
  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> (pready ##1 !pready || (psel && !penable)))
    else $error("pready not one cycle after setup");

  a_core_high_level: assert property (@(posedge pclk) disable iff (!presetn)
    (|event_flags[7:4]) |=> core_event_input_a)
    else $error("high level not shown on core input a");

  a_core_low_level: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(|event_flags[3:0]) |=> !core_event_input_b)
    else $error("low level stuck on core input b");

  a_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_commit && addr_hit && reg_ofs == efh_pkg::OFS_EVENT_FLAGS
     && pwdata[2] && !set_pulse[2]) |=> !event_flags[2])
    else $error("flag two not cleared by one");

  a_flag_w0_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_commit && reg_ofs == efh_pkg::OFS_EVENT_FLAGS
     && !pwdata[6] && event_flags[6]) |=> event_flags[6])
    else $error("flag six cleared by zero");

  a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_commit && addr_hit && reg_ofs == efh_pkg::OFS_EVENT_ENABLE)
    |=> state_ff.enable == $past(pwdata[7:0]))
    else $error("enable register not written");

  a_code_none: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && addr_hit && reg_ofs == efh_pkg::OFS_EVENT_TOPCODE
     && event_flags == 8'h00) |=> prdata == 32'h000000FF)
    else $error("code not all ones with no flag");

  a_code_top: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && addr_hit && reg_ofs == efh_pkg::OFS_EVENT_TOPCODE
     && event_flags[7]) |=> prdata == 32'h00000007)
    else $error("event seven did not win the code");

  a_summary_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && addr_hit && reg_ofs == efh_pkg::OFS_EVENT_SUMMARY)
    |=> prdata == {30'h00000000, $past(|event_flags[7:4]), $past(|event_flags[3:0])})
    else $error("summary read wrong");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (|(state_ff.irq_status & state_ff.irq_mask)) |-> irq)
    else $error("irq low with unmasked status");

endmodule // efh_top

// ===== verif/efh_src_model.sv
// Partner model: peripheral event sources and the two port pin requests
`timescale 1ns/1ps
module efh_src_model (
  // Clock
  input  wire logic       pclk,
  // Sources toward the handler
  output logic      [7:0] event_src,
  output logic            pin_zero,
  output logic            pin_one
);
  // ==========================================================
  // Idle levels
  initial
  begin
    event_src = 8'h00;
    pin_zero  = 1'b0;
    pin_one   = 1'b0;
  end

  // Index 8 and 9 are the pins; hold of 1 or more so the synchroniser sees it
  task automatic fire(input int n, input int hold);
    @(posedge pclk);
    if (n < 8)
      event_src[n] <= 1'b1;
    else if (n == 8)
      pin_zero <= 1'b1;
    else
      pin_one <= 1'b1;
    repeat (hold) @(posedge pclk);
    if (n < 8)
      event_src[n] <= 1'b0;
    else if (n == 8)
      pin_zero <= 1'b0;
    else
      pin_one <= 1'b0;
  endtask
endmodule // efh_src_model

// ===== verif/efh_top_tb.sv
// Self-checking testbench for the event flag handler
`timescale 1ns/1ps
module efh_top_tb;
  // ==========================================================
  // Signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  event_src;
  logic        pin_zero;
  logic        pin_one;
  logic        core_a;
  logic        core_b;
  logic        irq;
  int          error_cnt = 0;
  int          check_count = 0;

  always #4 pclk = ~pclk;

  efh_top u_efh_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_src(event_src), .input_port_pin_zero(pin_zero), .input_port_pin_one(pin_one),
    .core_event_input_a(core_a), .core_event_input_b(core_b), .irq(irq));
  efh_src_model u_efh_src_model (.pclk(pclk), .event_src(event_src), .pin_zero(pin_zero), .pin_one(pin_one));

  // ==========================================================
  // Compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge; data taken there
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {7'h00, a};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read");
    chk({31'h0, e}, 32'h0, "pslverr");
  endtask

  task automatic fire_wait(input int n, input int hold);
    u_efh_src_model.fire(n, hold);
    repeat (6) @(posedge pclk);
  endtask

  task automatic t_reset_values;
    rd(efh_pkg::OFS_EVENT_FLAGS, 32'h00);
    rd(efh_pkg::OFS_EVENT_ENABLE, 32'h00);
    rd(efh_pkg::OFS_EVENT_TOPCODE, 32'hFF);
    rd(efh_pkg::OFS_EVENT_SUMMARY, 32'h00);
    rd(efh_pkg::OFS_IRQ_STATUS, 32'h00);
    rd(efh_pkg::OFS_IRQ_MASK, 32'h00);
    $display("test reset_values done");
  endtask

  task automatic t_registers;
    logic [31:0] r;
    logic        e;
    wr(efh_pkg::OFS_EVENT_ENABLE, 32'hA5);
    rd(efh_pkg::OFS_EVENT_ENABLE, 32'hA5);
    wr(efh_pkg::OFS_EVENT_TOPCODE, 32'h03);
    rd(efh_pkg::OFS_EVENT_TOPCODE, 32'hFF);
    apb(1'b0, 5'h18, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(r, 32'h0, "unmapped data");
    $display("test registers done");
  endtask

  // Disabled rise is lost; enabled rises latch and outlive their sources
  task automatic t_events;
    wr(efh_pkg::OFS_EVENT_ENABLE, 32'h00);
    fire_wait(6, 3);
    rd(efh_pkg::OFS_EVENT_FLAGS, 32'h00);
    wr(efh_pkg::OFS_EVENT_ENABLE, 32'hFF);
    fire_wait(2, 2);
    fire_wait(5, 8);
    rd(efh_pkg::OFS_EVENT_FLAGS, 32'h24);
    rd(efh_pkg::OFS_EVENT_TOPCODE, 32'h05);
    rd(efh_pkg::OFS_EVENT_SUMMARY, 32'h03);
    chk({30'h0, core_a, core_b}, 32'h3, "core inputs");
    wr(efh_pkg::OFS_EVENT_FLAGS, 32'h20);
    rd(efh_pkg::OFS_EVENT_FLAGS, 32'h04);
    rd(efh_pkg::OFS_EVENT_TOPCODE, 32'h02);
    rd(efh_pkg::OFS_EVENT_SUMMARY, 32'h01);
    chk({30'h0, core_a, core_b}, 32'h1, "core after clear");
    wr(efh_pkg::OFS_EVENT_FLAGS, 32'h04);
    rd(efh_pkg::OFS_EVENT_TOPCODE, 32'hFF);
    $display("test events done");
  endtask

  task automatic t_pins;
    fire_wait(8, 2);
    fire_wait(9, 2);
    rd(efh_pkg::OFS_EVENT_FLAGS, 32'h11);
    rd(efh_pkg::OFS_EVENT_TOPCODE, 32'h04);
    fire_wait(7, 2);
    rd(efh_pkg::OFS_EVENT_TOPCODE, 32'h07);
    rd(efh_pkg::OFS_EVENT_SUMMARY, 32'h03);
    wr(efh_pkg::OFS_EVENT_FLAGS, 32'h01);
    rd(efh_pkg::OFS_EVENT_SUMMARY, 32'h02);
    wr(efh_pkg::OFS_EVENT_FLAGS, 32'h90);
    rd(efh_pkg::OFS_EVENT_FLAGS, 32'h00);
    $display("test pins done");
  endtask

  task automatic t_irq;
    wr(efh_pkg::OFS_IRQ_MASK, 32'h01);
    wr(efh_pkg::OFS_IRQ_STATUS, 32'hFF);
    fire_wait(1, 2);
    chk({31'h0, irq}, 32'h0, "masked irq");
    rd(efh_pkg::OFS_IRQ_STATUS, 32'h02);
    fire_wait(0, 2);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(efh_pkg::OFS_IRQ_STATUS, 32'h01);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd(efh_pkg::OFS_IRQ_STATUS, 32'h02);
    $display("test irq done");
  endtask

  // Reset in mid-run with flags standing
  task automatic t_rerun_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(efh_pkg::OFS_EVENT_FLAGS, 32'h00);
    rd(efh_pkg::OFS_EVENT_ENABLE, 32'h00);
    rd(efh_pkg::OFS_EVENT_TOPCODE, 32'hFF);
    chk({30'h0, core_a, core_b}, 32'h0, "core after reset");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("test rerun_reset done");
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_registers();
    t_events();
    t_pins();
    t_irq();
    t_rerun_reset();
    summarize();
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule // efh_top_tb
